// File: ppr_pkg.sv
// constants and carrier types for the panel power and rgb setup registers
package ppr_pkg;
  // command codes
  localparam logic [7:0] PPR_CMD_NEG_GAMMA = 8'hb1;
  localparam logic [7:0] PPR_CMD_COMP = 8'hb2;
  localparam logic [7:0] PPR_CMD_GAMP = 8'hb4;
  localparam logic [7:0] PPR_CMD_ASTEP = 8'hb5;
  localparam logic [7:0] PPR_CMD_GATE = 8'hb6;
  localparam logic [7:0] PPR_CMD_SRC = 8'hb7;
  localparam logic [7:0] PPR_CMD_TCON = 8'hba;
  localparam logic [7:0] PPR_CMD_VBP = 8'hbb;
  localparam logic [7:0] PPR_CMD_HBP = 8'hbc;
  localparam logic [7:0] PPR_CMD_VPORT = 8'hbd;
  localparam logic [7:0] PPR_CMD_SWRESET = 8'h01;
  // reset values
  localparam logic [7:0] PPR_RST_NEG_GAMMA = 8'h4d;
  localparam logic [7:0] PPR_RST_COMP = 8'h2c;
  localparam logic [7:0] PPR_RST_GAMP = 8'h88;
  localparam logic [7:0] PPR_RST_ASTEP = 8'h45;
  localparam logic [7:0] PPR_RST_GATE = 8'h89;
  localparam logic [7:0] PPR_RST_SRC = 8'h62;
  localparam logic [7:0] PPR_RST_TCON = 8'h00;
  localparam logic [7:0] PPR_RST_VBP = 8'h00;
  localparam logic [7:0] PPR_RST_HBP = 8'h08;
  localparam logic [7:0] PPR_RST_VPORT = 8'h00;
  // field masks: don't care bits are dropped at write time
  localparam logic [7:0] PPR_MASK_7B = 8'h7f;
  localparam logic [7:0] PPR_MASK_ASTEP = 8'h77;
  localparam logic [7:0] PPR_MASK_SRC = 8'h73;
  localparam logic [7:0] PPR_MASK_VPORT = 8'h9f;
  localparam logic [7:0] PPR_MASK_FULL = 8'hff;
  // neg gamma saturation
  localparam logic [6:0] PPR_NEG_GAMMA_MAX = 7'h79;
  // number of stored registers
  localparam int PPR_NREG = 10;
  localparam logic [3:0] PPR_IDX_NONE = 4'hf;

  typedef struct packed {
    logic cmd_param_select;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [7:0] data;
  } ppr_host_s;

  typedef struct packed {
    logic [6:0] negative_gamma_reference_code;
    logic [6:0] compensation_code;
    logic [3:0] neg_amp_supply_code;
    logic [3:0] pos_amp_supply_code;
    logic [2:0] neg_analog_supply_code;
    logic [2:0] pos_analog_supply_code;
    logic [3:0] gate_low_code;
    logic [3:0] gate_high_code;
    logic [2:0] neg_source_supply_code;
    logic [1:0] pos_source_supply_code;
    logic [2:0] gate_tune;
    logic [1:0] inversion_type_select;
    logic [6:0] vertical_porch_count;
    logic [6:0] horizontal_porch_count;
    logic direct_video_path_select;
    logic video_framing_select;
    logic vsync_invert;
    logic hsync_invert;
    logic data_enable_invert;
    logic dot_clock_invert;
  } ppr_cfg_s;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic enable;
    logic dot_clock;
  } ppr_video_s;

  typedef struct packed {
    logic vsync_active;
    logic hsync_active;
    logic data_accept;
    logic sample_on_fall;
    logic use_sync_framing;
  } ppr_vqual_s;
endpackage

// File: ppr_video_qual.sv
// polarity and framing qualification of rgb video control inputs
`timescale 1ns/1ns
module ppr_video_qual
  import ppr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // configuration
  input wire ppr_cfg_s cfg,
  // raw video controls
  input wire ppr_video_s video,
  // qualified controls
  output ppr_vqual_s qual
);
  typedef struct packed {
    ppr_vqual_s q;
  } ppr_vq_state_s;

  ppr_vq_state_s st;
  ppr_vq_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.q.vsync_active = video.vsync ~^ cfg.vsync_invert;
    next_st.q.hsync_active = video.hsync ~^ cfg.hsync_invert;
    next_st.q.sample_on_fall = cfg.dot_clock_invert;
    next_st.q.data_accept = video.enable ^ cfg.data_enable_invert;
    next_st.q.use_sync_framing = cfg.video_framing_select;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign qual = st.q;

  a_enable_polarity: assert property (@(posedge clk) disable iff (!nrst)
    clk_en |=> qual.data_accept == ($past(video.enable) ^ $past(cfg.data_enable_invert)))
    else $error("data accept does not follow enable polarity");
endmodule

// File: ppr_setup_regs.sv
// command addressed panel power and rgb setup register bank
`timescale 1ns/1ns
module ppr_setup_regs
  import ppr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // host command/parameter interface
  input wire ppr_host_s host,
  // rgb video controls
  input wire ppr_video_s video,
  // configuration outputs
  output ppr_cfg_s cfg,
  output logic [6:0] negative_gamma_level,
  output ppr_vqual_s video_qual
);
  typedef struct packed {
    logic [PPR_NREG-1:0][7:0] regs;
    logic [3:0] idx;
    logic wr_n_q;
    logic [6:0] neg_level;
  } ppr_state_s;

  ppr_state_s st;
  ppr_state_s next_st;
  logic [PPR_NREG-1:0][7:0] rst_vals;
  logic [PPR_NREG-1:0][7:0] masks;
  logic wr_rise;
  logic [3:0] cmd_idx;

  // command byte to storage index
  function automatic logic [3:0] cmd_to_idx(input logic [7:0] cmd);
    case (cmd)
      PPR_CMD_NEG_GAMMA: cmd_to_idx = 4'h0;
      PPR_CMD_COMP: cmd_to_idx = 4'h1;
      PPR_CMD_GAMP: cmd_to_idx = 4'h2;
      PPR_CMD_ASTEP: cmd_to_idx = 4'h3;
      PPR_CMD_GATE: cmd_to_idx = 4'h4;
      PPR_CMD_SRC: cmd_to_idx = 4'h5;
      PPR_CMD_TCON: cmd_to_idx = 4'h6;
      PPR_CMD_VBP: cmd_to_idx = 4'h7;
      PPR_CMD_HBP: cmd_to_idx = 4'h8;
      PPR_CMD_VPORT: cmd_to_idx = 4'h9;
      default: cmd_to_idx = PPR_IDX_NONE;
    endcase
  endfunction

  assign rst_vals = {PPR_RST_VPORT, PPR_RST_HBP, PPR_RST_VBP, PPR_RST_TCON, PPR_RST_SRC,
                     PPR_RST_GATE, PPR_RST_ASTEP, PPR_RST_GAMP, PPR_RST_COMP,
                     PPR_RST_NEG_GAMMA};
  assign masks = {PPR_MASK_VPORT, PPR_MASK_7B, PPR_MASK_7B, PPR_MASK_SRC, PPR_MASK_SRC,
                  PPR_MASK_FULL, PPR_MASK_ASTEP, PPR_MASK_FULL, PPR_MASK_7B, PPR_MASK_7B};

  assign wr_rise = host.write_strobe_n && !st.wr_n_q && host.read_strobe_n;
  assign cmd_idx = cmd_to_idx(host.data);

  always_comb begin
    next_st = st;
    next_st.wr_n_q = host.write_strobe_n;
    if (wr_rise) begin
      if (!host.cmd_param_select) begin
        // software reset reloads all defaults
        if (host.data == PPR_CMD_SWRESET) begin
          next_st.regs = rst_vals;
        end
        next_st.idx = cmd_idx;
      end else if (st.idx != PPR_IDX_NONE) begin
        // one parameter per command; later bytes are dropped
        next_st.regs[st.idx] = host.data & masks[st.idx];
        next_st.idx = PPR_IDX_NONE;
      end
    end
    if (st.regs[0][6:0] >= PPR_NEG_GAMMA_MAX) begin
      next_st.neg_level = PPR_NEG_GAMMA_MAX;
    end else begin
      next_st.neg_level = st.regs[0][6:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st.regs <= {PPR_RST_VPORT, PPR_RST_HBP, PPR_RST_VBP, PPR_RST_TCON, PPR_RST_SRC,
                  PPR_RST_GATE, PPR_RST_ASTEP, PPR_RST_GAMP, PPR_RST_COMP,
                  PPR_RST_NEG_GAMMA};
      st.idx <= PPR_IDX_NONE;
      st.wr_n_q <= 1'b1;
      st.neg_level <= PPR_RST_NEG_GAMMA[6:0];
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // field unpacking from stored bytes
  always_comb begin
    cfg = '0;
    cfg.negative_gamma_reference_code = st.regs[0][6:0];
    cfg.compensation_code = st.regs[1][6:0];
    cfg.neg_amp_supply_code = st.regs[2][7:4];
    cfg.pos_amp_supply_code = st.regs[2][3:0];
    cfg.neg_analog_supply_code = st.regs[3][6:4];
    cfg.pos_analog_supply_code = st.regs[3][2:0];
    cfg.gate_low_code = st.regs[4][7:4];
    cfg.gate_high_code = st.regs[4][3:0];
    cfg.neg_source_supply_code = st.regs[5][6:4];
    cfg.pos_source_supply_code = st.regs[5][1:0];
    cfg.gate_tune = st.regs[6][6:4];
    cfg.inversion_type_select = st.regs[6][1:0];
    cfg.vertical_porch_count = st.regs[7][6:0];
    cfg.horizontal_porch_count = st.regs[8][6:0];
    cfg.direct_video_path_select = st.regs[9][7];
    cfg.video_framing_select = st.regs[9][4];
    cfg.vsync_invert = st.regs[9][3];
    cfg.hsync_invert = st.regs[9][2];
    cfg.data_enable_invert = st.regs[9][1];
    cfg.dot_clock_invert = st.regs[9][0];
  end

  assign negative_gamma_level = st.neg_level;

  // qualifier registers its outputs, so video_qual stays flop-driven
  ppr_video_qual u_qual (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .cfg(cfg),
    .video(video),
    .qual(video_qual)
  );

  // command c taken, its parameter still pending; host may wait any number of clocks
  sequence s_cmd(logic [7:0] c);
    st.idx == cmd_to_idx(c);
  endsequence

  sequence s_param;
    clk_en && wr_rise && host.cmd_param_select;
  endsequence

  a_comp_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_COMP) ##1 s_param |=> cfg.compensation_code == $past(host.data[6:0]))
    else $error("compensation code not stored");
  a_gamp_split: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_GAMP) ##1 s_param |=> cfg.neg_amp_supply_code == $past(host.data[7:4])
      && cfg.pos_amp_supply_code == $past(host.data[3:0]))
    else $error("amp supply nibbles wrong");
  a_astep_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_ASTEP) ##1 s_param |=> st.regs[3][7] == 1'b0 && st.regs[3][3] == 1'b0)
    else $error("analog step don't care bit stored");
  a_gate_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_GATE) ##1 s_param |=> {cfg.gate_low_code, cfg.gate_high_code}
      == $past(host.data))
    else $error("gate level byte not stored");
  a_src_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_SRC) ##1 s_param |=> cfg.pos_source_supply_code == $past(host.data[1:0]))
    else $error("source supply code not stored");
  a_hbp_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_HBP) ##1 s_param |=> cfg.horizontal_porch_count == $past(host.data[6:0]))
    else $error("horizontal porch not stored");
  a_vport_bits: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_VPORT) ##1 s_param |=> cfg.video_framing_select == $past(host.data[4]))
    else $error("framing select not stored");
  a_gamma_sat: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && st.regs[0][6:0] > PPR_NEG_GAMMA_MAX |=> negative_gamma_level == PPR_NEG_GAMMA_MAX)
    else $error("negative gamma not saturated");
  a_no_edge_hold: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && !wr_rise |=> $stable(st.regs))
    else $error("register changed without write edge");
  a_vbp_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_VBP) ##1 s_param |=> cfg.vertical_porch_count == $past(host.data[6:0]))
    else $error("vertical porch not stored");
  a_gamma_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_NEG_GAMMA) ##1 s_param |=> cfg.negative_gamma_reference_code
      == $past(host.data[6:0]))
    else $error("negative gamma code not stored");
  // codes below the top pass through
  a_gamma_pass: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && st.regs[0][6:0] < PPR_NEG_GAMMA_MAX |=> negative_gamma_level
      == $past(st.regs[0][6:0]))
    else $error("negative gamma level not passed through");
  a_comp_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_COMP) ##1 s_param |=> st.regs[1][7] == 1'b0)
    else $error("compensation don't care bit stored");
  a_src_neg: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_SRC) ##1 s_param |=> cfg.neg_source_supply_code == $past(host.data[6:4]))
    else $error("negative source code not stored");
  a_src_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_SRC) ##1 s_param |=> st.regs[5][7] == 1'b0 && st.regs[5][3:2] == 2'b00)
    else $error("source don't care bits stored");
  a_tcon_write: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_TCON) ##1 s_param |=> cfg.gate_tune == $past(host.data[6:4])
      && cfg.inversion_type_select == $past(host.data[1:0]))
    else $error("tune or inversion not stored");
  a_tcon_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_TCON) ##1 s_param |=> st.regs[6][7] == 1'b0 && st.regs[6][3:2] == 2'b00)
    else $error("tune don't care bits stored");
  a_vport_inv: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_VPORT) ##1 s_param |=> cfg.direct_video_path_select == $past(host.data[7])
      && {cfg.vsync_invert, cfg.hsync_invert, cfg.data_enable_invert, cfg.dot_clock_invert}
      == $past(host.data[3:0]))
    else $error("video port polarity bits not stored");
  a_vport_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_cmd(PPR_CMD_VPORT) ##1 s_param |=> st.regs[9][6:5] == 2'b00)
    else $error("video port don't care bits stored");
  a_swreset_load: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && wr_rise && !host.cmd_param_select && host.data == PPR_CMD_SWRESET
      |=> st.regs[2] == PPR_RST_GAMP && st.regs[1] == PPR_RST_COMP)
    else $error("software reset did not reload defaults");
  a_read_gate: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && !host.read_strobe_n |=> $stable(st.regs))
    else $error("byte captured while read strobe low");
  a_stray_param: assert property (@(posedge clk) disable iff (!nrst)
    s_param && st.idx == PPR_IDX_NONE |=> $stable(st.regs))
    else $error("parameter without command stored");
  a_freeze_state: assert property (@(posedge clk) disable iff (!nrst)
    !clk_en |=> $stable(st))
    else $error("state changed while clock enable low");
endmodule

// File: ppr_host_model.sv
// host microcontroller model driving the command/parameter write port
`timescale 1ns/1ns
module ppr_host_model
  import ppr_pkg::*;
(
  // clock
  input wire logic clk,
  // command/parameter port towards the device
  output ppr_host_s host
);
  initial begin
    host.cmd_param_select = 1'b0;
    host.write_strobe_n = 1'b1;
    host.read_strobe_n = 1'b1;
    host.data = 8'h00;
  end

  // one byte per strobe
  // read strobe never leaves high, select set with the byte
  task automatic send(input logic dc, input logic [7:0] b);
    @(posedge clk);
    host.cmd_param_select <= dc;
    host.data <= b;
    host.write_strobe_n <= 1'b0;
    @(posedge clk);
    host.write_strobe_n <= 1'b1;
    @(posedge clk);
    // released bus shows the inverse, not a stale byte
    host.data <= ~b;
  endtask
endmodule

// File: tb_top.sv
// self-checking testbench for the panel setup register bank
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t got %h exp %h", $time, got, exp); end end
module tb_top
  import ppr_pkg::*;
;
  logic clk;
  logic nrst;
  logic clk_en;
  ppr_host_s host;
  ppr_video_s video;
  ppr_cfg_s cfg;
  ppr_cfg_s exp;
  logic [6:0] negative_gamma_level;
  ppr_vqual_s video_qual;
  ppr_vqual_s q;
  int mismatches;
  int samples_checked;
  logic [7:0] cmds [10] = '{8'hb1, 8'hb2, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hba, 8'hbb, 8'hbc, 8'hbd};

  ppr_host_model host_m (.clk(clk), .host(host));
  ppr_setup_regs dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .host(host), .video(video),
    .cfg(cfg), .negative_gamma_level(negative_gamma_level), .video_qual(video_qual));

  always #5 clk = ~clk;

  function automatic ppr_cfg_s apply(ppr_cfg_s c, logic [7:0] cmd, logic [7:0] p);
    case (cmd)
      8'hb1: c.negative_gamma_reference_code = p[6:0];
      8'hb2: c.compensation_code = p[6:0];
      8'hb4: {c.neg_amp_supply_code, c.pos_amp_supply_code} = p;
      8'hb5: {c.neg_analog_supply_code, c.pos_analog_supply_code} = {p[6:4], p[2:0]};
      8'hb6: {c.gate_low_code, c.gate_high_code} = p;
      8'hb7: {c.neg_source_supply_code, c.pos_source_supply_code} = {p[6:4], p[1:0]};
      8'hba: {c.gate_tune, c.inversion_type_select} = {p[6:4], p[1:0]};
      8'hbb: c.vertical_porch_count = p[6:0];
      8'hbc: c.horizontal_porch_count = p[6:0];
      8'hbd: {c.direct_video_path_select, c.video_framing_select, c.vsync_invert,
        c.hsync_invert, c.data_enable_invert, c.dot_clock_invert} = {p[7], p[4:0]};
      default: ;
    endcase
    return c;
  endfunction

  function automatic ppr_cfg_s dflt();
    ppr_cfg_s c;
    c = '0;
    c = apply(c, 8'hb1, 8'h4d);
    c = apply(c, 8'hb2, 8'h2c);
    c = apply(c, 8'hb4, 8'h88);
    c = apply(c, 8'hb5, 8'h45);
    c = apply(c, 8'hb6, 8'h89);
    c = apply(c, 8'hb7, 8'h62);
    c = apply(c, 8'hbc, 8'h08);
    return c;
  endfunction

  task automatic wr(input logic [7:0] cmd, input logic [7:0] p);
    host_m.send(1'b0, cmd);
    host_m.send(1'b1, p);
    exp = apply(exp, cmd, p);
  endtask

  // gamma level lags the field by one clock, so let one more edge pass
  task automatic chk();
    logic [6:0] g;
    @(posedge clk);
    @(negedge clk);
    g = (exp.negative_gamma_reference_code >= 7'h79) ? 7'h79 : exp.negative_gamma_reference_code;
    `CHK(cfg, exp)
    `CHK(negative_gamma_level, g)
  endtask

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    video = '0;
    exp = dflt();
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk();
    // all-ones pass sets every don't care bit; compensation written as 8'hd4, which stores code 7'h54
    foreach (cmds[i]) begin
      wr(cmds[i], (cmds[i] == 8'hb2) ? 8'hd4 : 8'hff);
      chk();
    end
    foreach (cmds[i]) begin
      wr(cmds[i], 8'h36);
      chk();
    end
    wr(8'hb1, 8'h78);
    chk();
    wr(8'hb1, 8'hfa);
    chk();
    wr(8'hb1, 8'h7f);
    chk();
    host_m.send(1'b1, 8'h11);
    chk();
    wr(8'hb4, 8'h12);
    host_m.send(1'b1, 8'h34);
    chk();
    host_m.send(1'b0, 8'hc0);
    host_m.send(1'b1, 8'h55);
    chk();
    // frozen clock enable must swallow a whole command pair
    @(posedge clk);
    clk_en <= 1'b0;
    host_m.send(1'b0, 8'hbc);
    host_m.send(1'b1, 8'h7f);
    clk_en <= 1'b1;
    chk();
    host_m.send(1'b0, 8'h01);
    exp = dflt();
    chk();
    wr(8'hb7, 8'h15);
    wr(8'hbb, 8'h44);
    chk();
    @(posedge clk);
    nrst <= 1'b0;
    exp = dflt();
    chk();
    @(posedge clk);
    nrst <= 1'b1;
    chk();
    for (int i = 0; i < 32; i++) begin
      wr(8'hbd, {i[4], 2'b11, i[4:0]});
      chk();
      for (int j = 0; j < 16; j++) begin
        @(posedge clk);
        video <= ppr_video_s'(j[3:0]);
        @(posedge clk);
        @(negedge clk);
        q.vsync_active = ~(video.vsync ^ exp.vsync_invert);
        q.hsync_active = ~(video.hsync ^ exp.hsync_invert);
        q.data_accept = video.enable ^ exp.data_enable_invert;
        q.sample_on_fall = exp.dot_clock_invert;
        q.use_sync_framing = exp.video_framing_select;
        `CHK(video_qual, q)
      end
    end
    stop_test();
  end
endmodule
